/* File: hdl/aimb_pkg.sv */
/*
 * constants, register map and carrier types for the alert interrupt mask bank.
 * assumes a byte-wide register port from the device's smbus/i2c target, 8-bit offsets.
 */
package aimb_pkg;

   // ***********************************************
   // register offsets
   // ***********************************************
   localparam logic [7:0] ALERT_STATUS_LO_OFS = 8'h10;
   localparam logic [7:0] ALERT_STATUS_HI_OFS = 8'h11;
   localparam logic [7:0] ALERT_MASK_LO_OFS = 8'h12;
   localparam logic [7:0] ALERT_MASK_HI_OFS = 8'h13;
   localparam logic [7:0] POWER_MASK_OFS = 8'h14;
   localparam logic [7:0] FAULT_MASK_OFS = 8'h15;
   localparam logic [7:0] EXT_STATUS_MASK_OFS = 8'h16;
   localparam logic [7:0] EXT_ALERT_MASK_OFS = 8'h17;

   // ***********************************************
   // reset values and writable-bit maps
   // ***********************************************
   localparam logic [15:0] ALERT_MASK_RST = 16'h6FFF;
   localparam logic [15:0] ALERT_MASK_WR = 16'hEFFF;
   localparam logic [7:0] POWER_MASK_RST = 8'hDF;
   localparam logic [7:0] POWER_MASK_WR = 8'hDF;
   localparam logic [7:0] FAULT_MASK_RST = 8'hBF;
   localparam logic [7:0] FAULT_MASK_WR = 8'hBF;
   localparam logic [7:0] EXT_STATUS_MASK_RST = 8'h01;
   localparam logic [7:0] EXT_STATUS_MASK_WR = 8'h01;
   localparam logic [7:0] EXT_ALERT_MASK_RST = 8'h01;
   localparam logic [7:0] EXT_ALERT_MASK_WR = 8'h01;
   localparam logic [15:0] ALERT_STATUS_RST = 16'h0000;
   localparam logic [15:0] ALERT_STATUS_WR = 16'hEFFF;

   // ***********************************************
   // field positions
   // ***********************************************
   localparam int ALERT_POWER_BIT = 1;
   localparam int ALERT_FAULT_BIT = 9;
   localparam int ALERT_EXT_STATUS_BIT = 13;
   localparam int ALERT_EXT_ALERT_BIT = 14;
   localparam int FAULT_DEFAULTS_BIT = 7;

   // ***********************************************
   // carriers
   // ***********************************************
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } aimb_req_t;

   typedef struct packed {
      logic [15:0] alert;
      logic [7:0] power;
      logic [7:0] fault;
      logic [7:0] ext_status;
      logic [7:0] ext_alert;
      logic full_defaults_restored_event;
   } aimb_events_t;

endpackage

/* File: hdl/aimb_top.sv */
/*
 * alert interrupt mask bank: mask registers, alert status with write-1-to-clear,
 * and the active-low alert request line.
 * assumes the smbus/i2c target decodes transfers into one-cycle byte strobes on req,
 * and that event inputs are one-cycle pulses synchronous to clk.
 */
// Overview of operation
// - mask bit 0 blocks its event, 1 lets it request an interrupt
// - alert mask bit 15 vendor resets 0; bits 14 and 13 reset 1
// - reserved mask bits read zero and ignore writes
// - alert mask bits 11..0 gate same-position alert status, reset to 1
// - power mask bits 7,6,4,3,2,1,0 writable, reset to 1
// - power mask bit 5 read-only zero; that event never interrupts
// - fault mask bit 7 returns to 1 when full defaults are restored
// - fault mask bits 5 down to 0 writable, reset to 1
// - protection faults are not gated by the fault mask
// - extended alert mask bit 0 writable reset 1; upper bits zero
// - alert status bits clear on written 1; written 0 leaves them
`timescale 1ns/100ps
module aimb_top (
   input wire logic clk,
   input wire logic srst,
   input wire aimb_pkg::aimb_req_t req,
   input wire aimb_pkg::aimb_events_t ev,
   output logic [7:0] rd_data,
   output logic alert_n
);

   // ***********************************************
   // state
   // ***********************************************
   logic [15:0] alert_mask;
   logic [7:0] power_mask;
   logic [7:0] fault_mask;
   logic [7:0] ext_status_mask;
   logic [7:0] ext_alert_mask;
   logic [15:0] alert_status;

   // ***********************************************
   // address decode
   // ***********************************************
   wire sel_st_lo = req.addr == aimb_pkg::ALERT_STATUS_LO_OFS;
   wire sel_st_hi = req.addr == aimb_pkg::ALERT_STATUS_HI_OFS;
   wire sel_am_lo = req.addr == aimb_pkg::ALERT_MASK_LO_OFS;
   wire sel_am_hi = req.addr == aimb_pkg::ALERT_MASK_HI_OFS;
   wire sel_pm = req.addr == aimb_pkg::POWER_MASK_OFS;
   wire sel_fm = req.addr == aimb_pkg::FAULT_MASK_OFS;
   wire sel_esm = req.addr == aimb_pkg::EXT_STATUS_MASK_OFS;
   wire sel_eam = req.addr == aimb_pkg::EXT_ALERT_MASK_OFS;

   // ***********************************************
   // mask next values
   // ***********************************************
   // read-only and reserved positions are zero in the write maps, so they never load
   wire [15:0] am_wr_data = {req.wdata, req.wdata} & aimb_pkg::ALERT_MASK_WR;
   wire [15:0] am_lane = {{8{sel_am_hi}}, {8{sel_am_lo}}} & {16{req.wr}};
   wire [15:0] next_alert_mask = (am_wr_data & am_lane) | (alert_mask & ~am_lane);
   wire [7:0] next_power_mask = req.wdata & aimb_pkg::POWER_MASK_WR;
   wire [7:0] fm_written = (req.wr && sel_fm) ? (req.wdata & aimb_pkg::FAULT_MASK_WR) :
      fault_mask;
   // the restore event outranks a same-cycle write so the bit cannot be left cleared
   wire [7:0] fm_restore = 8'h01 << aimb_pkg::FAULT_DEFAULTS_BIT;
   wire [7:0] next_fault_mask = ev.full_defaults_restored_event ?
      (fm_written | fm_restore) : fm_written;
   wire [7:0] next_ext_status_mask = req.wdata & aimb_pkg::EXT_STATUS_MASK_WR;
   wire [7:0] next_ext_alert_mask = req.wdata & aimb_pkg::EXT_ALERT_MASK_WR;

   // ***********************************************
   // event gating into alert status
   // ***********************************************
   // sub-register masks gate the summary bits; 1 passes, 0 blocks
   wire sum_power = |(ev.power & power_mask);
   // only the eight fault inputs and the restore event reach this; protection faults are
   // masked elsewhere and arrive, if at all, on their own path
   wire [7:0] fault_in = ev.fault |
      ({7'h00, ev.full_defaults_restored_event} << aimb_pkg::FAULT_DEFAULTS_BIT);
   // the restore event unmasks its own bit in the same cycle, so a written 0 cannot hide it
   wire [7:0] fm_gate = ev.full_defaults_restored_event ? (fault_mask | fm_restore) :
      fault_mask;
   wire sum_fault = |(fault_in & fm_gate);
   wire sum_ext_status = |(ev.ext_status & ext_status_mask);
   wire sum_ext_alert = |(ev.ext_alert & ext_alert_mask);
   wire [15:0] raw_set = ev.alert & aimb_pkg::ALERT_STATUS_WR;
   wire [15:0] summary_set = ({15'h0, sum_power} << aimb_pkg::ALERT_POWER_BIT) |
      ({15'h0, sum_fault} << aimb_pkg::ALERT_FAULT_BIT) |
      ({15'h0, sum_ext_status} << aimb_pkg::ALERT_EXT_STATUS_BIT) |
      ({15'h0, sum_ext_alert} << aimb_pkg::ALERT_EXT_ALERT_BIT);
   wire [15:0] status_set = raw_set | summary_set;

   // ***********************************************
   // write-1-to-clear, set wins
   // ***********************************************
   wire [15:0] st_lane = {{8{sel_st_hi}}, {8{sel_st_lo}}} & {16{req.wr}};
   wire [15:0] status_clr = {req.wdata, req.wdata} & st_lane;
   wire [15:0] next_alert_status = (alert_status & ~status_clr) | status_set;

   // ***********************************************
   // alert request and read data
   // ***********************************************
   // hard reset (bit 3) is maskable like the rest; software is expected to keep it open
   wire pending = |(alert_status & alert_mask);
   wire next_alert_n = ~pending;
   wire [7:0] next_rd_data =
      sel_st_lo ? alert_status[7:0] :
      sel_st_hi ? alert_status[15:8] :
      sel_am_lo ? alert_mask[7:0] :
      sel_am_hi ? alert_mask[15:8] :
      sel_pm ? power_mask :
      sel_fm ? fault_mask :
      sel_esm ? ext_status_mask :
      sel_eam ? ext_alert_mask : 8'h00;

   // ***********************************************
   // registers
   // ***********************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         alert_mask <= aimb_pkg::ALERT_MASK_RST;
         power_mask <= aimb_pkg::POWER_MASK_RST;
         fault_mask <= aimb_pkg::FAULT_MASK_RST;
         ext_status_mask <= aimb_pkg::EXT_STATUS_MASK_RST;
         ext_alert_mask <= aimb_pkg::EXT_ALERT_MASK_RST;
      end else begin
         alert_mask <= next_alert_mask;
         fault_mask <= next_fault_mask;
         if (req.wr && sel_pm) begin
            power_mask <= next_power_mask;
         end
         if (req.wr && sel_esm) begin
            ext_status_mask <= next_ext_status_mask;
         end
         if (req.wr && sel_eam) begin
            ext_alert_mask <= next_ext_alert_mask;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         alert_status <= aimb_pkg::ALERT_STATUS_RST;
         alert_n <= 1'b1;
         rd_data <= 8'h00;
      end else begin
         alert_status <= next_alert_status;
         alert_n <= next_alert_n;
         if (req.rd) begin
            rd_data <= next_rd_data;
         end
      end
   end

endmodule // aimb_top

/* File: testbench/aimb_host_model.sv */
/* port manager host model: byte register strobes.
   assumes clk and rd_data from the bench. */
`timescale 1ns/100ps
module aimb_host_model (
   input wire logic clk,
   input wire logic [7:0] rd_data,
   output aimb_pkg::aimb_req_t req
);
   // ****
   // byte access
   // ****
   initial req = '0;
   // status clear is a write of ones
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      req <= '{1'h1, 1'h0, a, v};
      @(posedge clk);
      req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      req <= '{1'h0, 1'h1, a, 8'h00};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
      #1 v = rd_data;
   endtask
endmodule // aimb_host_model

/* File: testbench/aimb_top_sva.sv */
/* port assertions for the mask bank.
   assumes a bind onto aimb_top. */
`timescale 1ns/100ps
module aimb_top_sva (
   input wire logic clk,
   input wire logic srst,
   input wire aimb_pkg::aimb_req_t req,
   input wire aimb_pkg::aimb_events_t ev,
   input wire logic [7:0] rd_data,
   input wire logic alert_n
);
   // ****
   // properties
   // ****
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   property p_rst; disable iff (1'h0) srst |=> alert_n && rd_data == 8'h00; endproperty
   property p_am12; req.rd && req.addr == 8'h13 |=> !rd_data[4]; endproperty
   property p_pm5; req.rd && req.addr == 8'h14 |=> !rd_data[5]; endproperty
   property p_fm6; req.rd && req.addr == 8'h15 |=> !rd_data[6]; endproperty
   property p_ext; req.rd && req.addr[7:1] == 7'h0B |=> rd_data[7:1] == 7'h00; endproperty
   property p_restore;
      ev.full_defaults_restored_event ##1 (req.rd && req.addr == 8'h15) |=> rd_data[7];
   endproperty
   // a falling line needs an event two edges back or a write one or two edges back
   property p_fell; $fell(alert_n) |-> $past(|ev, 2) || $past(req.wr, 2) || $past(req.wr); endproperty
   property p_rise; $rose(alert_n) |-> $past(req.wr, 2) || $past(req.wr); endproperty
   a_rst: assert property (p_rst) else $error("alert line or read data not idle in reset");
   a_am12: assert property (p_am12) else $error("alert mask bit 12 not zero");
   a_pm5: assert property (p_pm5) else $error("power mask bit 5 not zero");
   a_fm6: assert property (p_fm6) else $error("fault mask bit 6 not zero");
   a_ext: assert property (p_ext) else $error("extended mask upper bits not zero");
   a_restore: assert property (p_restore) else $error("restore left fault bit 7 low");
   a_fell: assert property (p_fell) else $error("alert line fell without cause");
   a_rise: assert property (p_rise) else $error("alert line released without a write");
   c_fell: cover property ($fell(alert_n));
   c_restore: cover property (ev.full_defaults_restored_event);
   c_rise: cover property ($rose(alert_n));
endmodule // aimb_top_sva
bind aimb_top aimb_top_sva u_sva (.clk(clk), .srst(srst), .req(req), .ev(ev),
   .rd_data(rd_data), .alert_n(alert_n));

/* File: testbench/tb_alert_interrupt_mask_bank.sv */
/* self-checking bench for the mask bank.
   assumes the host model and checker compiled first. */
`timescale 1ns/100ps
`define check(n, e, a) checks_done++; if ((a) !== (e)) begin fail_count++; $display("MISMATCH %s exp %h got %h", n, e, a); end
module tb_alert_interrupt_mask_bank;
   // ****
   // bench
   // ****
   localparam logic [47:0] RST_V = 48'hFF6FDFBF0101;
   localparam logic [47:0] ONE_V = 48'hFFEFDFBF0101;
   logic clk = 1'h0;
   logic srst = 1'h1;
   aimb_pkg::aimb_events_t ev = '0;
   aimb_pkg::aimb_req_t req;
   logic [7:0] rd_data;
   logic alert_n;
   logic [7:0] d;
   int fail_count = 0;
   int checks_done = 0;
   always #20 clk = ~clk;
   aimb_host_model host_u (.clk(clk), .rd_data(rd_data), .req(req));
   aimb_top dut_u (.clk(clk), .srst(srst), .req(req), .ev(ev), .rd_data(rd_data), .alert_n(alert_n));
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      host_u.rd(a, d);
      `check("reg", e, d)
   endtask
   // status or mask lands on the write's last edge; the registered line follows on the first of the two edges
   task automatic wrs(input logic [7:0] a, input logic [7:0] v);
      host_u.wr(a, v);
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic pulse(input aimb_pkg::aimb_events_t p);
      @(posedge clk);
      ev <= p;
      @(posedge clk);
      ev <= '0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   initial begin
      #200000;
      fail_count++;
      final_report;
   end
   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'h0;
      for (int i = 0; i < 6; i++) rchk(8'h12 + 8'(i), RST_V[47 - 8 * i -: 8]);
      rchk(8'h20, 8'h00);
      for (int i = 0; i < 6; i++) host_u.wr(8'h12 + 8'(i), 8'hFF);
      for (int i = 0; i < 6; i++) rchk(8'h12 + 8'(i), ONE_V[47 - 8 * i -: 8]);
      for (int i = 0; i < 6; i++) host_u.wr(8'h12 + 8'(i), 8'h00);
      for (int i = 0; i < 6; i++) rchk(8'h12 + 8'(i), 8'h00);
      $display("test mask_access done");
      pulse('{full_defaults_restored_event:1'h1, default:'0});
      `check("alert_n", 1'h1, alert_n)
      rchk(8'h15, 8'h80);
      wrs(8'h13, 8'h02);
      `check("alert_n", 1'h0, alert_n)
      wrs(8'h11, 8'h00);
      `check("alert_n", 1'h0, alert_n)
      wrs(8'h11, 8'h02);
      `check("alert_n", 1'h1, alert_n)
      $display("test restore done");
      wrs(8'h12, 8'h08);
      pulse('{alert:16'h0008, default:'0});
      `check("alert_n", 1'h0, alert_n)
      wrs(8'h10, 8'h08);
      `check("alert_n", 1'h1, alert_n)
      wrs(8'h12, 8'h00);
      pulse('{alert:16'h0008, default:'0});
      `check("alert_n", 1'h1, alert_n)
      wrs(8'h12, 8'h08);
      `check("alert_n", 1'h0, alert_n)
      wrs(8'h10, 8'h08);
      $display("test alert_gate done");
      wrs(8'h12, 8'h02);
      wrs(8'h14, 8'hFF);
      pulse('{power:8'h20, default:'0});
      `check("alert_n", 1'h1, alert_n)
      pulse('{power:8'h01, default:'0});
      `check("alert_n", 1'h0, alert_n)
      $display("test power_gate done");
      host_u.wr(8'h15, 8'h00);
      @(posedge clk);
      ev <= '{full_defaults_restored_event:1'h1, default:'0};
      fork
         host_u.rd(8'h15, d);
         begin
            @(posedge clk);
            ev <= '0;
         end
      join
      `check("fault_mask", 8'h80, d)
      $display("test restore_read done");
      final_report;
   end
endmodule // tb_alert_interrupt_mask_bank
